// [shared/adc_seq_defines.svh]
// Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes an 8-bit register port and a 10 MHz reference clock.
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_RES_HI   8'h1e
`define ADDR_RES_LO   8'h9e
`define ADDR_CTRL     8'h1f
`define ADDR_CFG      8'h9f
`define ADDR_FLAG     8'h0c

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_ON_BIT   0
`define CTRL_GO_BIT   2
`define CTRL_CHS_LSB  3
`define CTRL_CLK_LSB  6
`define CTRL_WMASK    8'hfd
`define CFG_JUST_BIT  7
`define CFG_WMASK     8'h8f
`define FLAG_DONE_BIT 6
`define CTRL_RST      8'h00
`define CFG_RST       8'h00
`define RES_RST       8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
`define RC_TAD_NS     4000
`define RC_TAD_CYC    (`RC_TAD_NS / `CLK_PERIOD_NS)
`define DIV_FAST      2
`define DIV_MID       8
`define DIV_SLOW      32
`define CONV_TADS     12
`define RECOV_TADS    2
`define RES_BITS      10

`endif

// [shared/adc_seq_pkg.sv]
// Types shared by the converter sequencer modules.
// Assumes the constants header is included by each user.
package adc_seq_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_CONV   = 3'b010,
    ST_FINISH = 3'b011,
    ST_RECOV  = 3'b100
  } seq_state_e;

  // Conversion clock sources.
  typedef enum logic [1:0] {
    CLK_DIV2  = 2'b00,
    CLK_DIV8  = 2'b01,
    CLK_DIV32 = 2'b10,
    CLK_RC    = 2'b11
  } clk_sel_e;

endpackage

// [hdl/adc_tad_divider.sv]
// Conversion bit period tick generator.
// Assumes a free-running reference clock; the run input restarts the count.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module adc_tad_divider
  import adc_seq_pkg::*;
#(
  parameter logic [7:0] RC_CYC = 8'(`RC_TAD_CYC)
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  output logic            tick
);

  logic [7:0] cnt_q;
  logic [7:0] limit;

  // Select the period in reference clocks for each source.
  always_comb begin
    case (clk_sel)
      CLK_DIV2:  limit = 8'(`DIV_FAST);
      CLK_DIV8:  limit = 8'(`DIV_MID);
      CLK_DIV32: limit = 8'(`DIV_SLOW);
      CLK_RC:    limit = RC_CYC;
      default:   limit = 8'(`DIV_FAST);
    endcase
  end

  // The count restarts while idle so the first tick lands one full period later.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (!run || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // A switch to a faster source in mid-count ticks at once instead of wrapping the counter.
  assign tick = run && (cnt_q >= limit - 8'h01);

  a_fast_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick && clk_sel == CLK_DIV2 |=> !tick)
    else $error("fast divider ticked twice in a row");

endmodule

// [hdl/adc_port_map.sv]
// Decoder from the port configuration code to pin roles and reference use.
// Assumes a registered configuration code at its input.
`timescale 1ns/1ps

module adc_port_map (
  input  wire logic [3:0] cfg_code,
  output logic [7:0]      pin_is_analog,
  output logic            vref_pos_ext,
  output logic            vref_neg_ext,
  output logic [3:0]      chan_count,
  output logic [1:0]      ref_count
);

  // Pins are ordered channel 7 down to channel 0; a reference pin is not analog.
  always_comb begin
    vref_pos_ext = 1'b0;
    vref_neg_ext = 1'b0;
    case (cfg_code)
      4'h0: pin_is_analog = 8'hff;
      4'h1: begin pin_is_analog = 8'hf7; vref_pos_ext = 1'b1; end
      4'h2: pin_is_analog = 8'h1f;
      4'h3: begin pin_is_analog = 8'h17; vref_pos_ext = 1'b1; end
      4'h4: pin_is_analog = 8'h0b;
      4'h5: begin pin_is_analog = 8'h03; vref_pos_ext = 1'b1; end
      4'h6, 4'h7: pin_is_analog = 8'h00;
      4'h8: begin pin_is_analog = 8'hf3; vref_pos_ext = 1'b1; vref_neg_ext = 1'b1; end
      4'h9: pin_is_analog = 8'h3f;
      4'ha: begin pin_is_analog = 8'h37; vref_pos_ext = 1'b1; end
      4'hb: begin pin_is_analog = 8'h33; vref_pos_ext = 1'b1; vref_neg_ext = 1'b1; end
      4'hc: begin pin_is_analog = 8'h13; vref_pos_ext = 1'b1; vref_neg_ext = 1'b1; end
      4'hd: begin pin_is_analog = 8'h03; vref_pos_ext = 1'b1; vref_neg_ext = 1'b1; end
      4'he: pin_is_analog = 8'h01;
      4'hf: begin pin_is_analog = 8'h01; vref_pos_ext = 1'b1; vref_neg_ext = 1'b1; end
      default: pin_is_analog = 8'hff;
    endcase
  end

  // Usable channel and reference pin counts follow from the decoded roles.
  always_comb begin
    chan_count = 4'h0;
    for (int i = 0; i < 8; i++) begin
      chan_count = chan_count + {3'b000, pin_is_analog[i]};
    end
    ref_count = {1'b0, vref_pos_ext} + {1'b0, vref_neg_ext};
  end

endmodule

// [hdl/adc_seq_top.sv]
// Successive-approximation converter sequencer with its register file.
// Assumes an 8-bit register port, a 10 MHz reference clock and an analog
// front end that reports one comparator decision per trial value.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module adc_seq_top
  import adc_seq_pkg::*;
#(
  parameter logic [7:0] RC_CYC = 8'(`RC_TAD_CYC)
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       cmp_above,
  output logic [2:0]      channel_sel,
  output logic            hold_connect,
  output logic [9:0]      sar_trial,
  output logic            module_on,
  output logic [7:0]      pin_is_analog,
  output logic            vref_pos_ext,
  output logic            vref_neg_ext,
  output logic [3:0]      analog_chan_count,
  output logic [1:0]      ref_pin_count,
  output logic            conversion_done_flag
);

  // ****************************************
  // Registers and state
  // ****************************************
  seq_state_e state_q;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic [7:0] rdata_q;
  logic       done_q;
  logic       go_q;
  logic [9:0] sar_q;
  logic [3:0] bit_idx_q;
  logic [1:0] recov_cnt_q;
  logic [3:0] conv_ticks_q;
  logic       tick;
  logic       busy;
  logic       complete;
  logic       abort;
  logic       wr_ctrl;
  logic [9:0] result;

  // Write strobe decode is shared by several register processes.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  assign wr_ctrl  = reg_wr && hit(reg_addr, `ADDR_CTRL);
  assign busy     = (state_q == ST_SAMPLE) || (state_q == ST_CONV) || (state_q == ST_FINISH);
  assign complete = (state_q == ST_FINISH) && tick && go_q;
  assign abort    = busy && !go_q;

  // Final result: trial register as it stands; last bit decision folded in at the tenth bit tick, before finishing.
  assign result = sar_q;

  // ****************************************
  // Submodules
  // ****************************************

  // Bit period tick runs only while a conversion or recovery is under way.
  // An abort restarts the count, so that recovery still lasts two full periods.
  adc_tad_divider #(
    .RC_CYC (RC_CYC)
  ) u_div (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     ((state_q != ST_IDLE) && !abort),
    .clk_sel (ctrl_q[`CTRL_CLK_LSB +: 2]),
    .tick    (tick)
  );

  // Pin roles decoded from the configuration code.
  adc_port_map u_map (
    .cfg_code      (cfg_q[3:0]),
    .pin_is_analog (pin_is_analog),
    .vref_pos_ext  (vref_pos_ext),
    .vref_neg_ext  (vref_neg_ext),
    .chan_count    (analog_chan_count),
    .ref_count     (ref_pin_count)
  );

  // ****************************************
  // Register file
  // ****************************************

  // Control register; the go bit is kept separately.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata & `CTRL_WMASK & ~(8'h01 << `CTRL_GO_BIT);
    end
  end

  // Go starts only if the module was already on; completion clears it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_q <= 1'b0;
    end else if (complete) begin
      go_q <= 1'b0;
    end else if (wr_ctrl) begin
      go_q <= reg_wdata[`CTRL_GO_BIT] && ctrl_q[`CTRL_ON_BIT];
    end
  end

  // Configuration register keeps only its implemented bits.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CFG_RST;
    end else if (reg_wr && hit(reg_addr, `ADDR_CFG)) begin
      cfg_q <= reg_wdata & `CFG_WMASK;
    end
  end

  // Done flag: a completion in the same cycle as a clear wins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (reg_wr && hit(reg_addr, `ADDR_FLAG)) begin
      done_q <= reg_wdata[`FLAG_DONE_BIT];
    end
  end

  // Result pair: loaded justified at completion, else writable as plain storage.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_hi_q <= `RES_RST;
      res_lo_q <= `RES_RST;
    end else if (complete) begin
      if (cfg_q[`CFG_JUST_BIT]) begin
        res_hi_q <= {6'b000000, result[9:8]};
        res_lo_q <= result[7:0];
      end else begin
        res_hi_q <= result[9:2];
        res_lo_q <= {result[1:0], 6'b000000};
      end
    end else begin
      if (reg_wr && hit(reg_addr, `ADDR_RES_HI)) begin
        res_hi_q <= reg_wdata;
      end
      if (reg_wr && hit(reg_addr, `ADDR_RES_LO)) begin
        res_lo_q <= reg_wdata;
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CTRL:   rdata_q <= ctrl_q | (8'(go_q) << `CTRL_GO_BIT);
        `ADDR_CFG:    rdata_q <= cfg_q;
        `ADDR_RES_HI: rdata_q <= res_hi_q;
        `ADDR_RES_LO: rdata_q <= res_lo_q;
        `ADDR_FLAG:   rdata_q <= 8'(done_q) << `FLAG_DONE_BIT;
        default:      rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************

  // One sampling tick, ten bit ticks and one finishing tick make twelve periods.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else if (!ctrl_q[`CTRL_ON_BIT]) begin
      state_q <= ST_IDLE;
    end else if (abort) begin
      state_q <= ST_RECOV;
    end else begin
      case (state_q)
        ST_IDLE:   if (go_q) state_q <= ST_SAMPLE;
        ST_SAMPLE: if (tick) state_q <= ST_CONV;
        ST_CONV:   if (tick && bit_idx_q == 4'h0) state_q <= ST_FINISH;
        ST_FINISH: if (tick) state_q <= ST_RECOV;
        ST_RECOV:  if (tick && recov_cnt_q == 2'(`RECOV_TADS - 1)) state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Trial register: decide the current bit and raise the next trial bit.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sar_q     <= 10'h000;
      bit_idx_q <= 4'h0;
    end else if (state_q == ST_SAMPLE && tick) begin
      sar_q     <= 10'h200;
      bit_idx_q <= 4'(`RES_BITS - 1);
    end else if (state_q == ST_CONV && tick) begin
      sar_q[bit_idx_q] <= cmp_above;
      if (bit_idx_q != 4'h0) begin
        sar_q[bit_idx_q - 4'h1] <= 1'b1;
        bit_idx_q <= bit_idx_q - 4'h1;
      end
    end
  end

  // Recovery period counter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      recov_cnt_q <= 2'b00;
    end else if (state_q != ST_RECOV) begin
      recov_cnt_q <= 2'b00;
    end else if (tick) begin
      recov_cnt_q <= recov_cnt_q + 2'b01;
    end
  end

  // Helper count of bit periods since the start, read by the checks below.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_ticks_q <= 4'h0;
    end else if (!busy) begin
      conv_ticks_q <= 4'h0;
    end else if (tick) begin
      conv_ticks_q <= conv_ticks_q + 4'h1;
    end
  end

  // ****************************************
  // Front end and status outputs
  // ****************************************

  // Hold capacitor tracks the channel only while idle and on; no discharge path.
  assign hold_connect = (state_q == ST_IDLE) && ctrl_q[`CTRL_ON_BIT];
  assign channel_sel  = ctrl_q[`CTRL_CHS_LSB +: 3];
  assign sar_trial    = sar_q;
  assign module_on    = ctrl_q[`CTRL_ON_BIT];
  assign reg_rdata    = rdata_q;
  assign conversion_done_flag = done_q;

  // ****************************************
  // Checks
  // ****************************************

  sequence s_finish_tick;
    state_q == ST_FINISH && tick && go_q;
  endsequence

  sequence s_loaded;
    !go_q && done_q;
  endsequence

  a_right_just_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    complete && cfg_q[`CFG_JUST_BIT] |=> res_hi_q[7:2] == 6'b000000)
    else $error("right justified high byte has nonzero upper bits");

  a_left_just_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    complete && !cfg_q[`CFG_JUST_BIT] |=> res_lo_q[5:0] == 6'b000000)
    else $error("left justified low byte has nonzero lower bits");

  a_cfg_gap_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADDR_CFG |=> reg_rdata[6:4] == 3'b000)
    else $error("unimplemented configuration bits read nonzero");

  a_all_analog_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfg_q[3:0] == 4'h0 |-> pin_is_analog == 8'hff && analog_chan_count == 4'h8
    && ref_pin_count == 2'b00)
    else $error("code zero is not all analog with supply references");

  a_done_with_go: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_finish_tick |=> s_loaded)
    else $error("completion did not clear go and set done together");

  a_conv_twelve: assert property (@(posedge ref_clk) disable iff (!rst_n)
    complete |-> conv_ticks_q == 4'(`CONV_TADS - 1))
    else $error("conversion did not last twelve bit periods");

  a_recov_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == ST_RECOV |-> !hold_connect)
    else $error("hold capacitor connected during recovery");

  a_recov_two_tad: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(state_q == ST_IDLE) && ctrl_q[`CTRL_ON_BIT] |-> $past(recov_cnt_q) ==
    2'(`RECOV_TADS - 1))
    else $error("acquisition resumed before two bit periods");

  a_abort_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    abort && !reg_wr |=> $stable(res_hi_q) && $stable(res_lo_q) && state_q != ST_CONV)
    else $error("aborted conversion changed the result");

endmodule

// [tb/adc_front_model.sv]
// Behavioural analog front end: track-and-hold plus comparator.
// Assumes the testbench supplies the analog level as a 10-bit code on vin.
`timescale 1ns/1ps

module adc_front_model (
  input  wire logic       ref_clk,
  input  wire logic       hold_connect,
  input  wire logic [9:0] sar_trial,
  input  wire logic [9:0] vin,
  output logic            cmp_above
);
  logic [9:0] held_q = 10'h000;

  // The capacitor follows the input only while it is connected to the channel.
  always_ff @(posedge ref_clk) begin
    if (hold_connect) begin
      held_q <= vin;
    end
  end

  // The comparator judges the held charge, which is never discharged between conversions.
  assign cmp_above = (held_q >= sar_trial);
endmodule

// [tb/adc_sequencer_port_config_tb.sv]
// Self-checking testbench for the converter sequencer and its register port.
// Assumes the design and the front end model are compiled ahead of it.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"

module adc_sequencer_port_config_tb
  import adc_seq_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cmp_above;
  logic [2:0] channel_sel;
  logic       hold_connect;
  logic [9:0] sar_trial;
  logic       module_on;
  logic [7:0] pin_is_analog;
  logic       vref_pos_ext;
  logic       vref_neg_ext;
  logic [3:0] analog_chan_count;
  logic [1:0] ref_pin_count;
  logic       conversion_done_flag;
  logic [9:0] vin = 10'h000;
  int         n_fail = 0;
  int         n_compared = 0;
  logic [7:0] rd_v;
  logic [7:0] lo_v;
  logic [15:0] map_tbl [16] = '{16'hff80, 16'hf776, 16'h1f50, 16'h1746, 16'h0b30, 16'h0326,
    16'h0000, 16'h0000, 16'hf36b, 16'h3f60, 16'h3756, 16'h334b, 16'h133b, 16'h032b,
    16'h0110, 16'h011b}; // {analog pins, channels, reference pins, external refs}
  int         div_tbl [4] = '{2, 8, 32, 4};

  // The clock toggles every half period of 100 ns.
  always #50 ref_clk = ~ref_clk;

  adc_seq_top #(.RC_CYC(8'h04)) dut_u (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .cmp_above            (cmp_above),
    .channel_sel          (channel_sel),
    .hold_connect         (hold_connect),
    .sar_trial            (sar_trial),
    .module_on            (module_on),
    .pin_is_analog        (pin_is_analog),
    .vref_pos_ext         (vref_pos_ext),
    .vref_neg_ext         (vref_neg_ext),
    .analog_chan_count    (analog_chan_count),
    .ref_pin_count        (ref_pin_count),
    .conversion_done_flag (conversion_done_flag)
  );

  adc_front_model front_u (
    .ref_clk      (ref_clk),
    .hold_connect (hold_connect),
    .sar_trial    (sar_trial),
    .vin          (vin),
    .cmp_above    (cmp_above)
  );

  // ****************************************
  // Access tasks
  // ****************************************
  // Compares one value and counts the outcome.
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Issues a one-cycle write strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Issues a one-cycle read strobe and takes the data in the following cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Runs one full conversion and checks timing, flags and the justified result.
  task automatic run_conv(input logic [1:0] sel, input logic just, input logic [9:0] v);
    int n;
    logic [7:0] ctl;
    ctl = {sel, 3'h5, 3'h1};
    vin <= v;
    wr_reg(`ADDR_CFG, {just, 7'h00});
    wr_reg(`ADDR_CTRL, ctl);
    chk("channel select", 16'h0005, {13'h0, channel_sel});
    chk("module on", 16'h0001, {15'h0, module_on});
    // Waits out the acquisition after the channel change before go.
    repeat (4) @(posedge ref_clk);
    wr_reg(`ADDR_CTRL, ctl | 8'h04);
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("conversion length", 16'h0001, 16'(n >= 12 * div_tbl[sel] && n <= 12 * div_tbl[sel] + 2));
    rd_reg(`ADDR_CTRL, rd_v);
    chk("go after completion", {8'h00, ctl}, {8'h00, rd_v});
    n = 0;
    while (hold_connect !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("recovery length", 16'h0001, 16'(n >= 2 * div_tbl[sel] - 4 && n <= 2 * div_tbl[sel] + 1));
    rd_reg(`ADDR_RES_HI, rd_v);
    rd_reg(`ADDR_RES_LO, lo_v);
    chk("result pair", just ? {6'h00, v} : {v, 6'h00}, {rd_v, lo_v});
    rd_reg(`ADDR_FLAG, rd_v);
    chk("done flag bit", 16'h0001, {15'h0, rd_v[6]});
    wr_reg(`ADDR_FLAG, 8'h00);
    chk("done flag cleared", 16'h0000, {15'h0, conversion_done_flag});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  // Main sequence of register accesses and conversions.
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_reg(`ADDR_CFG, rd_v);
    chk("config reset", 16'h0000, {8'h00, rd_v});
    rd_reg(`ADDR_CTRL, rd_v);
    chk("control reset", 16'h0000, {8'h00, rd_v});
    chk("pins after reset", map_tbl[0], {pin_is_analog, analog_chan_count, ref_pin_count,
        vref_pos_ext, vref_neg_ext});
    rd_reg(8'h55, rd_v);
    chk("unmapped read", 16'h0000, {8'h00, rd_v});
    wr_reg(`ADDR_CFG, 8'hff);
    rd_reg(`ADDR_CFG, rd_v);
    chk("config unimplemented bits", 16'h008f, {8'h00, rd_v});
    for (int c = 0; c < 16; c++) begin
      wr_reg(`ADDR_CFG, 8'(c));
      chk("port map", map_tbl[c], {pin_is_analog, analog_chan_count, ref_pin_count,
          vref_pos_ext, vref_neg_ext});
    end
    wr_reg(`ADDR_CTRL, 8'h00);
    wr_reg(`ADDR_CTRL, 8'h04);
    rd_reg(`ADDR_CTRL, rd_v);
    chk("go while off", 16'h0000, {8'h00, rd_v});
    for (int s = 0; s < 4; s++) begin
      run_conv(2'(s), s[0], 10'h2a5 ^ 10'(s * 97));
    end
    run_conv(2'h0, 1'b1, 10'h3ff);
    // Abort runs on the divide-by-32 source, the one that suits a 10 MHz clock.
    wr_reg(`ADDR_CTRL, 8'h81);
    vin <= 10'h011;
    repeat (3) @(posedge ref_clk);
    wr_reg(`ADDR_CTRL, 8'h85);
    repeat (60) @(posedge ref_clk);
    wr_reg(`ADDR_CTRL, 8'h81);
    repeat (120) @(posedge ref_clk);
    #1;
    chk("done after abort", 16'h0000, {15'h0, conversion_done_flag});
    chk("hold after abort", 16'h0001, {15'h0, hold_connect});
    rd_reg(`ADDR_RES_LO, lo_v);
    rd_reg(`ADDR_RES_HI, rd_v);
    chk("result after abort", 16'h03ff, {rd_v, lo_v});
    tally_and_finish();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(100 * 50000);
    n_fail++;
    tally_and_finish();
  end
endmodule
